// >>> core/forc_ctrl.sv
// Option-byte, data-flash erase routing and shared RAM controller
`timescale 1ns/1ps
module forc_ctrl
	import forc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Shared RAM system port
	input  wire logic [RAM_AW-1:0] ram_addr,
	input  wire logic [31:0] ram_wdata,
	input  wire logic        ram_wr,
	input  wire logic        ram_rd,
	output logic      [31:0] ram_rdata,
	// Decoded options and status
	output forc_opts_s       opts,
	output logic      [31:0] bank0_wp,
	output logic             op_end_irq
);
	logic [31:0] shared_ram [RAM_WORDS];
	logic [7:0]  ob0 [OB0_BYTES];
	logic [31:0] ob1_flash;
	forc_state_e state;
	logic [1:0]  shared_ram_cmd;
	logic [1:0]  ram_cmd_pend;
	logic        basic_ram_ready, prog_ram_ready;
	logic        option_write_enable, option0_erase, option0_program, start;
	logic        data_flash_mass_erase, option_reload, op_end_irq_en;
	logic        busy, program_error, program_sequence_error, op_end_flag;
	logic [31:0] option1_ctrl_status_reg, ob1_req;
	logic        option1_locked, option1_start, option_error;
	logic [31:0] option_status_reg, obdata_lo;
	logic [31:0] cnt;
	logic [RAM_AW-1:0] idx;
	logic [OB0_AW-1:0] ob0_addr;
	logic        ram_fill;

	// Register decode
	wire wr_ws   = clk_en && reg_wr && reg_addr == OFS_WAIT_STATE;
	wire wr_ctl  = clk_en && reg_wr && reg_addr == OFS_CTL1;
	wire wr_stat = clk_en && reg_wr && reg_addr == OFS_STAT1;
	wire wr_ob1  = clk_en && reg_wr && reg_addr == OFS_OB1CS;
	wire wr_dlo  = clk_en && reg_wr && reg_addr == OFS_OBDATA_LO;
	wire wr_dhi  = clk_en && reg_wr && reg_addr == OFS_OBDATA_HI;
	wire wr_oba  = clk_en && reg_wr && reg_addr == OFS_OB0_ADDR;
	wire idle    = state == ST_IDLE;

	// Option-1 request legality: fixed size, load clear, partition not reserved
	wire ob1_ok   = ob1_req[11:8] == OB1_SIZE_OK && !ob1_req[OB1_LOAD_BIT]
		&& ob1_req[7:4] != 4'h0 && !option1_locked;
	wire ob1_part = ob1_req[11:4] != ob1_flash[11:4];
	// Double word slot of option block 0 is erased when all bytes read FF
	wire [OB0_AW-1:0] ob_base = {ob0_addr[OB0_AW-1:2], 2'h0};
	wire ob_blank = (ob0[ob_base] & ob0[ob_base+1] & ob0[ob_base+2]
		& ob0[ob_base+3]) == OB_BLANK;

	// Option-0 decode with complement checks
	wire [7:0] spc_raw  = ob0[0];
	wire [7:0] user_raw = ob0[2];
	wire spc_bad  = spc_raw  != ~ob0[1];
	wire user_bad = user_raw != ~ob0[3];
	wire [7:0] spc  = spc_bad  ? OB_BLANK : spc_raw;
	wire [7:0] user = user_bad ? OB_BLANK : user_raw;
	wire [3:0] wp_bad;
	wire [31:0] wp_val;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_wp
			assign wp_bad[g] = ob0[8+2*g] != ~ob0[9+2*g];
			assign wp_val[8*g +: 8] = wp_bad[g] ? OB_BLANK : ob0[8+2*g];
		end
	endgenerate
	wire load_err = spc_bad || user_bad || (|wp_bad);

	// Register read mux
	wire [31:0] rd_mux =
		reg_addr == OFS_WAIT_STATE ? {28'h0, prog_ram_ready, basic_ram_ready, shared_ram_cmd} :
		reg_addr == OFS_CTL1  ? {25'h0, op_end_irq_en, option_reload, data_flash_mass_erase,
			start, option0_program, option0_erase, option_write_enable} :
		reg_addr == OFS_STAT1 ? {28'h0, op_end_flag, program_sequence_error, program_error, busy} :
		reg_addr == OFS_OB1CS ? option1_ctrl_status_reg :
		reg_addr == OFS_OBSTAT ? option_status_reg :
		reg_addr == OFS_WP0   ? bank0_wp :
		32'h0;

	assign op_end_irq = op_end_flag && op_end_irq_en;

	// Shared RAM: software writes in every state except ST_RAMCLR, which clears or fills it; software reads in every state
	always_ff @(posedge clk) begin
		if (clk_en && state == ST_RAMCLR)
			shared_ram[idx] <= {32{ram_fill}};
		else if (clk_en && ram_wr)
			shared_ram[ram_addr] <= ram_wdata;
		if (clk_en && ram_rd)
			ram_rdata <= shared_ram[ram_addr];
	end

	// Option block 0 storage, modelled flash cells
	always_ff @(posedge clk) begin
		if (clk_en && state == ST_OBERS) begin
			for (int i = 0; i < OB0_BYTES; i++)
				ob0[i] <= OB_BLANK;
		end else if (clk_en && state == ST_OBPRG && ob_blank) begin
			for (int i = 0; i < 4; i++)
				ob0[ob_base+i] <= obdata_lo[8*i +: 8];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RELOAD;
			shared_ram_cmd <= 2'h0;
			ram_cmd_pend <= 2'h0;
			basic_ram_ready <= 1'b0;
			prog_ram_ready <= 1'b0;
			{option_write_enable, option0_erase, option0_program, start} <= 4'h0;
			{data_flash_mass_erase, option_reload, op_end_irq_en} <= 3'h0;
			{busy, program_error, program_sequence_error, op_end_flag} <= 4'h8;
			option1_ctrl_status_reg <= OB1_RESET;
			ob1_req <= OB1_RESET;
			ob1_flash <= OB1_RESET;
			option1_locked <= 1'b0;
			option1_start <= 1'b0;
			option_status_reg <= 32'h0;
			option_error <= 1'b0;
			bank0_wp <= 32'h0;
			opts <= '0;
			obdata_lo <= 32'h0;
			ob0_addr <= '0;
			cnt <= 32'h0;
			idx <= '0;
			ram_fill <= 1'b0;
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
			if (wr_ws && idle)
				shared_ram_cmd <= reg_wdata[WS_CMD_LSB +: 2];
			// Shared RAM command written while busy waits for idle
			if (wr_ws && !idle)
				ram_cmd_pend <= reg_wdata[WS_CMD_LSB +: 2];
			else if (idle && ram_cmd_pend != 2'h0) begin
				shared_ram_cmd <= ram_cmd_pend;
				ram_cmd_pend <= 2'h0;
			end
			if (wr_ctl) begin
				option_write_enable <= option_write_enable || reg_wdata == OPTION_WRITE_ENABLE_KEY;
				if (reg_wdata != OPTION_WRITE_ENABLE_KEY) begin
					option0_erase <= reg_wdata[CTL_OPTION0_ERASE_BIT];
					option0_program <= reg_wdata[CTL_OPTION0_PROGRAM_BIT];
					start <= start || reg_wdata[CTL_START_BIT];
					data_flash_mass_erase <= reg_wdata[CTL_DATA_FLASH_MASS_ERASE_BIT];
					option_reload <= option_reload || reg_wdata[CTL_RELOAD_BIT];
					op_end_irq_en <= reg_wdata[CTL_OP_END_IRQ_EN_BIT];
				end
			end
			if (wr_ob1 && !busy) begin
				ob1_req <= {reg_wdata[31:15], 1'b0, 1'b0, reg_wdata[12:0]};
				option1_start <= option1_start || reg_wdata[OB1_START_BIT];
			end
			if (wr_oba)
				ob0_addr <= reg_wdata[OB0_AW-1:0];
			if (wr_dlo)
				obdata_lo <= reg_wdata;
			// Hardware set wins over software clear (write one to clear)
			if (wr_stat) begin
				if (reg_wdata[ST_PROGRAM_ERROR_BIT]) program_error <= 1'b0;
				if (reg_wdata[ST_PROGRAM_SEQUENCE_ERROR_BIT]) program_sequence_error <= 1'b0;
				if (reg_wdata[ST_END_BIT]) op_end_flag <= 1'b0;
			end
			case (state)
				ST_IDLE: begin
					// Commands stay pending until the sequencer is idle
					if (shared_ram_cmd == CMD_BASIC || shared_ram_cmd == CMD_PROG) begin
						state <= ST_RAMCLR;
						ram_fill <= shared_ram_cmd == CMD_PROG;
						basic_ram_ready <= 1'b0;
						prog_ram_ready <= 1'b0;
						idx <= '0;
						busy <= 1'b1;
					end else if (option_reload) begin
						state <= ST_RELOAD;
						busy <= 1'b1;
					end else if (start && data_flash_mass_erase) begin
						state <= ST_DFERS;
						cnt <= 32'h0;
						busy <= 1'b1;
					end else if (start && option0_erase && option_write_enable) begin
						state <= ST_OBERS;
						busy <= 1'b1;
					end else if (wr_dhi && option0_program && option_write_enable) begin
						state <= ST_OBPRG;
						busy <= 1'b1;
					end else if (option1_start && option_write_enable) begin
						option1_start <= 1'b0;
						if (!ob1_ok)
							program_sequence_error <= 1'b1;
						else begin
							state <= ST_OB1WR;
							cnt <= ob1_part ? 32'h0 : PAGES_DF * PAGE_ERASE_CYC;
							busy <= 1'b1;
						end
					end else if (!wr_ctl)
						// A start that matches no operation is dropped
						start <= 1'b0;
				end
				ST_RAMCLR: begin
					idx <= idx + 1'b1;
					if (idx == RAM_AW'(RAM_WORDS - 1)) begin
						basic_ram_ready <= !ram_fill;
						prog_ram_ready <= ram_fill;
						shared_ram_cmd <= 2'h0;
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_OBERS: begin
					op_end_flag <= 1'b1;
					start <= 1'b0;
					busy <= 1'b0;
					state <= ST_IDLE;
				end
				ST_OBPRG: begin
					if (ob_blank)
						op_end_flag <= 1'b1;
					else
						program_error <= 1'b1;
					busy <= 1'b0;
					state <= ST_IDLE;
				end
				ST_DFERS: begin
					cnt <= cnt + 32'h1;
					if (cnt == PAGES_DF * PAGE_ERASE_CYC - 1) begin
						op_end_flag <= 1'b1;
						start <= 1'b0;
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_OB1WR: begin
					cnt <= cnt + 32'h1;
					if (cnt >= PAGES_DF * PAGE_ERASE_CYC) begin
						ob1_flash <= ob1_req;
						op_end_flag <= 1'b1;
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_RELOAD: begin
					option_reload <= 1'b0;
					option1_ctrl_status_reg <= {ob1_flash[31:16], 1'b0, 1'b0,
						ob1_flash[31:16] == OB1_LOCK_KEY, ob1_flash[12:0]};
					option1_locked <= ob1_flash[31:16] == OB1_LOCK_KEY;
					option_error <= load_err;
					option_status_reg <= {15'h0, load_err, user, spc};
					bank0_wp <= wp_val;
					opts.spc <= spc == SPC_NONE ? 2'h0 : spc == SPC_HIGH ? 2'h2 : 2'h1;
					opts.bor_en <= !user[7];
					opts.update_boot <= user[4];
					opts.boot_bank1 <= !user[3] && user[4];
					opts.standby_reset <= !user[2];
					opts.deepsleep_reset <= !user[1];
					opts.hw_watchdog <= !user[0];
					busy <= 1'b0;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

// >>> core/forc_pkg.sv
// Package: constants, register map and types of the option and shared RAM controller
package forc_pkg;
	// Shared RAM geometry: 4KB as 1024 words of 32 bits
	localparam int RAM_WORDS = 1024;
	localparam int RAM_AW    = 10;

	// Register word offsets (byte addresses)
	localparam logic [7:0] OFS_WAIT_STATE = 8'h00;
	localparam logic [7:0] OFS_CTL1       = 8'h04;
	localparam logic [7:0] OFS_STAT1      = 8'h08;
	localparam logic [7:0] OFS_OB1CS      = 8'h0C;
	localparam logic [7:0] OFS_OBSTAT     = 8'h10;
	localparam logic [7:0] OFS_WP0        = 8'h14;
	localparam logic [7:0] OFS_OBDATA_LO  = 8'h18;
	localparam logic [7:0] OFS_OBDATA_HI  = 8'h1C;
	localparam logic [7:0] OFS_OB0_ADDR   = 8'h20;

	// Wait-state register fields
	localparam int WS_CMD_LSB  = 0;
	localparam int WS_BRAM_BIT = 2;
	localparam int WS_PRAM_BIT = 3;
	localparam logic [1:0] CMD_BASIC = 2'h2;
	localparam logic [1:0] CMD_PROG  = 2'h1;

	// Bank-1 control fields
	localparam int CTL_OPTION_WRITE_ENABLE_BIT = 0;
	localparam int CTL_OPTION0_ERASE_BIT = 1;
	localparam int CTL_OPTION0_PROGRAM_BIT = 2;
	localparam int CTL_START_BIT = 3;
	localparam int CTL_DATA_FLASH_MASS_ERASE_BIT = 4;
	localparam int CTL_RELOAD_BIT = 5;
	localparam int CTL_OP_END_IRQ_EN_BIT = 6;
	localparam logic [31:0] OPTION_WRITE_ENABLE_KEY = 32'h0000_A5A5;

	// Bank-1 status fields
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_PROGRAM_ERROR_BIT = 1;
	localparam int ST_PROGRAM_SEQUENCE_ERROR_BIT = 2;
	localparam int ST_END_BIT   = 3;

	// Option block 1 fields
	localparam logic [15:0] OB1_LOCK_KEY   = 16'h33CC;
	localparam int OB1_LOAD_BIT  = 15;
	localparam int OB1_START_BIT = 14;
	localparam int OB1_LOCK_BIT  = 13;
	localparam logic [3:0] OB1_SIZE_OK  = 4'hF;
	localparam logic [31:0] OB1_RESET   = 32'h0000_0FF0;

	// Option block 0 decode
	localparam logic [7:0] SPC_NONE = 8'hA5;
	localparam logic [7:0] SPC_HIGH = 8'hCC;
	localparam logic [7:0] OB_BLANK = 8'hFF;
	localparam int OB0_BYTES = 20;
	localparam int OB0_AW    = 5;
	localparam int OB0_DW    = 2;
	localparam int PAGES_DF  = 32;

	// Data-flash page erase time, in microseconds, and cycles at 125 MHz
	localparam int CLK_MHZ          = 125;
	localparam int PAGE_ERASE_US    = 2;
	localparam int PAGE_ERASE_CYC   = PAGE_ERASE_US * CLK_MHZ;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_RAMCLR = 7'h02,
		ST_OBERS  = 7'h04,
		ST_OBPRG  = 7'h08,
		ST_OB1WR  = 7'h10,
		ST_DFERS  = 7'h20,
		ST_RELOAD = 7'h40
	} forc_state_e;

	typedef struct packed {
		logic [1:0] spc;
		logic       bor_en;
		logic       update_boot;
		logic       boot_bank1;
		logic       standby_reset;
		logic       deepsleep_reset;
		logic       hw_watchdog;
	} forc_opts_s;
endpackage

// >>> test/forc_host.sv
// Software-side bus master model of the register port
`timescale 1ns/1ps
module forc_host
	import forc_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Register port
	output logic      [7:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr  = 8'h00;
		reg_wdata = 32'h0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end
	// One-cycle write strobe; data inverted once released
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~v;
	endtask
	// One-cycle read strobe; data taken in the following cycle
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask
endmodule

// >>> test/forc_ctrl_props.sv
// Port checker of the option and shared RAM controller
`timescale 1ns/1ps
module forc_ctrl_props
	import forc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Observed ports
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire forc_opts_s  opts,
	input  wire logic [31:0] bank0_wp,
	input  wire logic        op_end_irq
);
	logic       rd_q;
	logic [7:0] ra_q;
	logic       irq_q;
	wire        ob;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q  <= 1'b0;
			ra_q  <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			rd_q  <= reg_rd;
			ra_q  <= reg_addr;
			irq_q <= op_end_irq;
		end
	end
	assign ob = rd_q && ra_q == OFS_OBSTAT;
	property p_one_type; rd_q && ra_q == OFS_WAIT_STATE |-> !(reg_rdata[2] && reg_rdata[3]); endproperty
	a_one_type: assert property (p_one_type) else $error("both RAM types ready");
	property p_end_irq; rd_q && ra_q == OFS_STAT1 && irq_q |-> reg_rdata[ST_END_BIT]; endproperty
	a_end_irq: assert property (p_end_irq) else $error("irq without end flag");
	property p_spc;
		ob |-> opts.spc == (reg_rdata[7:0] == SPC_NONE ? 2'h0 : reg_rdata[7:0] == SPC_HIGH ? 2'h2 : 2'h1);
	endproperty
	a_spc: assert property (p_spc) else $error("security decode wrong");
	property p_bor; ob |-> opts.bor_en == !reg_rdata[15] && opts.update_boot == reg_rdata[12]; endproperty
	a_bor: assert property (p_bor) else $error("brown-out or update decode wrong");
	property p_low; ob |-> {opts.standby_reset, opts.deepsleep_reset, opts.hw_watchdog} == ~reg_rdata[10:8]; endproperty
	a_low: assert property (p_low) else $error("low user bits decode wrong");
	property p_boot; ob |-> opts.boot_bank1 == (!reg_rdata[11] && reg_rdata[12]); endproperty
	a_boot: assert property (p_boot) else $error("boot bank decode wrong");
	property p_wp; rd_q && ra_q == OFS_WP0 |-> reg_rdata == bank0_wp; endproperty
	a_wp: assert property (p_wp) else $error("protect output differs");
	property p_lock; rd_q && ra_q == OFS_OB1CS && reg_rdata[OB1_LOCK_BIT] |-> reg_rdata[31:16] == OB1_LOCK_KEY; endproperty
	a_lock: assert property (p_lock) else $error("locked without lock value");
endmodule
bind forc_ctrl forc_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .opts(opts), .bank0_wp(bank0_wp), .op_end_irq(op_end_irq));

// >>> test/forc_ctrl_tb.sv
// Self-checking testbench of the option and shared RAM controller
`timescale 1ns/1ps
module forc_ctrl_tb
	import forc_pkg::*;
;
	logic              clk, rst_n, wr, rd, irq, ram_wr, ram_rd, clk_en;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, ram_wdata, ram_rdata, wp, d;
	logic [RAM_AW-1:0] ram_addr;
	forc_opts_s        opts;
	int                mismatches, samples_checked;
	logic [7:0]        spc_t [3] = '{8'hA5, 8'hCC, 8'h3C};
	logic [7:0]        usr_t [3] = '{8'h0A, 8'h15, 8'h80};
	logic [1:0]        spc_e [3] = '{2'h0, 2'h2, 2'h1};
	forc_host h (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
	forc_ctrl DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_wr(ram_wr), .ram_rd(ram_rd), .ram_rdata(ram_rdata), .opts(opts), .bank0_wp(wp),
		.op_end_irq(irq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task results;
		$display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task idle;
		d = 32'h1;
		for (int i = 0; i < 12000 && d[ST_BUSY_BIT] !== 1'b0; i++) h.rd(OFS_STAT1, d);
		if (d[ST_BUSY_BIT] !== 1'b0) chk(d & 32'h1, 32'h0);
	endtask
	task wram(input logic [RAM_AW-1:0] a, input logic [31:0] v);
		@(posedge clk);
		ram_addr  <= a;
		ram_wdata <= v;
		ram_wr    <= 1'b1;
		@(posedge clk);
		ram_wr    <= 1'b0;
	endtask
	task rram(input logic [RAM_AW-1:0] a, input logic [31:0] e);
		@(posedge clk);
		ram_addr <= a;
		ram_rd   <= 1'b1;
		@(posedge clk);
		ram_rd   <= 1'b0;
		#1 chk(ram_rdata, e);
	endtask
	task pg(input logic [7:0] a, input logic [31:0] lo);
		h.wr(OFS_OB0_ADDR, {24'h0, a});
		h.wr(OFS_OBDATA_LO, lo);
		h.wr(OFS_OBDATA_HI, 32'hFFFFFFFF);
		idle();
	endtask
	task t_ram(input logic [1:0] c, input logic [31:0] f);
		h.rd(OFS_WAIT_STATE, d);
		h.wr(OFS_WAIT_STATE, {30'h0, c});
		h.rd(OFS_STAT1, d);
		chk(d & 32'h1, 32'h1);
		idle();
		h.rd(OFS_WAIT_STATE, d);
		chk(d & 32'hF, (c == CMD_BASIC) ? 32'h4 : 32'h8);
		rram(10'h005, f);
		rram(10'h3FF, f);
		wram(10'h005, 32'h5A5AC3C3);
		rram(10'h005, 32'h5A5AC3C3);
	endtask
	task t_ob0(input int i);
		logic [7:0]  s, u;
		logic [31:0] w;
		s = spc_t[i];
		u = usr_t[i];
		w = 32'h12345678;
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_CTL1, OPTION_WRITE_ENABLE_KEY);
		h.rd(OFS_CTL1, d);
		chk(d & 32'h1, 32'h1);
		h.wr(OFS_CTL1, 32'h42);
		h.wr(OFS_CTL1, 32'h4A);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d, 32'h8);
		chk({31'h0, irq}, 32'h1);
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_CTL1, 32'h4);
		pg(8'h00, {~u, u, ~s, s});
		pg(8'h04, 32'hFF00FF00);
		pg(8'h08, {~w[15:8], w[15:8], (i == 2) ? w[7:0] : ~w[7:0], w[7:0]});
		pg(8'h0C, {~w[31:24], w[31:24], ~w[23:16], w[23:16]});
		pg(8'h10, 32'hFF00FF00);
		h.rd(OFS_STAT1, d);
		chk(d & 32'h6, 32'h0);
		pg(8'h00, {~u, u, ~s, s});
		h.rd(OFS_STAT1, d);
		chk(d & 32'h2, 32'h2);
		h.wr(OFS_CTL1, 32'h20);
		idle();
		h.rd(OFS_OBSTAT, d);
		chk(d, {15'h0, i == 2, u, s});
		h.rd(OFS_WP0, d);
		chk(d, (i == 2) ? {w[31:8], 8'hFF} : w);
		chk({24'h0, opts}, {24'h0, spc_e[i], ~u[7], u[4], ~u[3] & u[4], ~u[2:0]});
	endtask
	task t_hold;
		@(posedge clk);
		clk_en <= 1'b0;
		h.wr(OFS_WAIT_STATE, {30'h0, CMD_PROG});
		@(posedge clk);
		clk_en <= 1'b1;
		h.rd(OFS_WAIT_STATE, d);
		chk(d & 32'hF, 32'h4);
	endtask
	task t_df;
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_CTL1, OPTION_WRITE_ENABLE_KEY);
		h.wr(OFS_CTL1, 32'h18);
		repeat (PAGES_DF * PAGE_ERASE_CYC - 1000) @(posedge clk);
		h.rd(OFS_STAT1, d);
		chk(d & 32'h1, 32'h1);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d & 32'h9, 32'h8);
	endtask
	task t_ob1;
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_CTL1, OPTION_WRITE_ENABLE_KEY);
		h.wr(OFS_OB1CS, 32'h4010);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d & 32'h4, 32'h4);
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_OB1CS, 32'hCF10);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d & 32'h4, 32'h4);
		h.wr(OFS_STAT1, 32'hE);
		h.wr(OFS_OB1CS, 32'h33CC4F10);
		repeat (PAGES_DF * PAGE_ERASE_CYC - 1000) @(posedge clk);
		h.rd(OFS_STAT1, d);
		chk(d & 32'h1, 32'h1);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d & 32'h4, 32'h0);
		h.rd(OFS_OB1CS, d);
		chk(d & 32'h2000, 32'h0);
		h.wr(OFS_CTL1, 32'h20);
		idle();
		h.rd(OFS_OB1CS, d);
		chk(d & 32'hFFFF2000, 32'h33CC2000);
		h.wr(OFS_CTL1, OPTION_WRITE_ENABLE_KEY);
		h.wr(OFS_OB1CS, 32'h4F20);
		idle();
		h.rd(OFS_STAT1, d);
		chk(d & 32'h4, 32'h4);
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		ram_addr = '0;
		ram_wdata = 32'h0;
		ram_wr = 1'b0;
		ram_rd = 1'b0;
		clk_en = 1'b1;
		mismatches = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_ram(CMD_PROG, 32'hFFFFFFFF);
		t_ram(CMD_BASIC, 32'h0);
		t_hold();
		for (int i = 0; i < 3; i++) t_ob0(i);
		t_df();
		t_ob1();
		results();
	end
endmodule
